// [pmf_panel.sv]
`timescale 1ns/1ps
module pmf_panel #(
  parameter int LAMP_CYC  = pmf_pkg::LAMP_CYC,
  parameter int CONV_CYC  = pmf_pkg::CONV_CYC,
  parameter int BLINK_CYC = pmf_pkg::BLINK_CYC,
  parameter int SEC_CYC   = pmf_pkg::SEC_CYC,
  parameter int DEB_CYC   = pmf_pkg::DEB_CYC
) (
  // system
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // front panel buttons, raw pins, active high
  input  wire logic         btn_prog_i,
  input  wire logic         btn_up_i,
  input  wire logic         btn_dn_i,
  // display, lamps, relays, analog
  output pmf_pkg::pmf_disp_t disp_o,
  output logic              disp_pwm_o,
  output logic      [2:0]   lamp_o,
  output logic      [2:0]   relay_o,
  output logic      [15:0]  aout_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] step_after(input logic [4:0] s, input logic [3:0] hw);
    logic [4:0] n;
    n = s + 5'h01;
    case (s)
      pmf_pkg::S_BR:  n = hw[pmf_pkg::CTRL_AOUT_BIT] ? pmf_pkg::S_AHI : pmf_pkg::S_END;
      pmf_pkg::S_ALO: n = pmf_pkg::S_END;
      pmf_pkg::S_HY1: n = hw[pmf_pkg::CTRL_RLY_LSB + 1] ? s + 5'h01 :
                          hw[pmf_pkg::CTRL_RLY_LSB + 2] ? pmf_pkg::S_SP3 : pmf_pkg::S_END;
      pmf_pkg::S_HY2: n = hw[pmf_pkg::CTRL_RLY_LSB + 2] ? pmf_pkg::S_SP3 : pmf_pkg::S_END;
      pmf_pkg::S_HY3: n = pmf_pkg::S_END;
      default:        n = s + 5'h01;
    endcase
    return n;
  endfunction

  function automatic logic signed [15:0] lim_hi(input logic [4:0] s);
    logic signed [15:0] v;
    v = pmf_pkg::VAL_MAX;
    if (s == pmf_pkg::S_DP) v = pmf_pkg::DP_MAX;
    if (s == pmf_pkg::S_BR) v = pmf_pkg::BR_MAX;
    for (int g = 0; g < 3; g++) if (s == pmf_pkg::DIR_STEP[g]) v = pmf_pkg::DIR_MAX;
    return v;
  endfunction

  function automatic logic signed [15:0] lim_lo(input logic [4:0] s);
    logic signed [15:0] v;
    v = pmf_pkg::VAL_MIN;
    if (s == pmf_pkg::S_DP) v = '0;
    if (s == pmf_pkg::S_BR) v = pmf_pkg::BR_MIN;
    for (int g = 0; g < 3; g++) begin
      if (s == pmf_pkg::DIR_STEP[g] || s == pmf_pkg::MK_STEP[g] || s == pmf_pkg::BK_STEP[g]) begin
        v = '0;
      end
    end
    return v;
  endfunction

  function automatic logic [7:0] lane(input logic [31:0] o, input logic [31:0] n,
                                      input logic [3:0] sel, input int b);
    return sel[b] ? n[8*b +: 8] : o[8*b +: 8];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmf_pkg::pmf_mode_t  mode_reg;
  logic [4:0]          step_reg;
  logic [1:0]          vsp_reg;
  logic [31:0]         lamp_cnt_reg;
  logic [31:0]         conv_cnt_reg;
  logic [31:0]         blink_cnt_reg;
  logic [31:0]         sec_cnt_reg;
  logic                conv_tick_reg;
  logic                sec_tick_reg;
  logic                blink_reg;
  logic [2:0]          held_w;
  logic [2:0]          combo_reg;
  logic                evt_w;
  logic signed [15:0]  par_reg [0:pmf_pkg::N_PAR-1];
  logic [3:0]          ctrl_reg;
  logic [31:0]         rdin_reg;
  logic signed [15:0]  rd_reg;
  logic                pos_reg;
  logic                neg_reg;
  logic signed [15:0]  peak_reg;
  logic signed [15:0]  valley_reg;
  logic [1:0]          pwm_cnt_reg;
  logic [2:0]          trip_w;
  logic signed [31:0]  aout_q;
  logic                wb_req_w;
  logic signed [15:0]  rdin_val_w;

  // ----------------------------------------------------------------
  // buttons
  // ----------------------------------------------------------------
  pmf_debounce #(.DEB_CYC(DEB_CYC)) u_db_prog (
    .clk_i(clk_i), .rst_i(rst_i), .btn_i(btn_prog_i), .level_o(held_w[0])
  );
  pmf_debounce #(.DEB_CYC(DEB_CYC)) u_db_up (
    .clk_i(clk_i), .rst_i(rst_i), .btn_i(btn_up_i), .level_o(held_w[1])
  );
  pmf_debounce #(.DEB_CYC(DEB_CYC)) u_db_dn (
    .clk_i(clk_i), .rst_i(rst_i), .btn_i(btn_dn_i), .level_o(held_w[2])
  );

  // everything pressed together is remembered, then acted on once all are up
  assign evt_w = (held_w == 3'h0) && (combo_reg != 3'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i || evt_w) begin
      combo_reg <= 3'h0;
    end else begin
      combo_reg <= combo_reg | held_w;
    end
  end

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || conv_cnt_reg == 32'(CONV_CYC - 1)) begin
      conv_cnt_reg  <= '0;
      conv_tick_reg <= !rst_i;
    end else begin
      conv_cnt_reg  <= conv_cnt_reg + 32'h1;
      conv_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sec_cnt_reg == 32'(SEC_CYC - 1)) begin
      sec_cnt_reg  <= '0;
      sec_tick_reg <= !rst_i;
    end else begin
      sec_cnt_reg  <= sec_cnt_reg + 32'h1;
      sec_tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == 32'(BLINK_CYC - 1)) begin
      blink_cnt_reg <= '0;
      blink_reg     <= !blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // menu
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg     <= pmf_pkg::M_LAMP;
      step_reg     <= pmf_pkg::S_DP;
      vsp_reg      <= 2'h0;
      lamp_cnt_reg <= '0;
    end else begin
      case (mode_reg)
        pmf_pkg::M_LAMP: begin
          // buttons are ignored until the lamp test is over
          if (lamp_cnt_reg == 32'(LAMP_CYC - 1)) begin
            mode_reg <= pmf_pkg::M_RUN;
          end else begin
            lamp_cnt_reg <= lamp_cnt_reg + 32'h1;
          end
        end
        pmf_pkg::M_RUN: begin
          if (evt_w) begin
            case (combo_reg)
              pmf_pkg::C_PU: begin
                mode_reg <= pmf_pkg::M_EDIT;
                step_reg <= pmf_pkg::S_DP;
              end
              pmf_pkg::C_PD: begin
                mode_reg <= pmf_pkg::M_EDIT;
                step_reg <= pmf_pkg::S_SP1;
              end
              pmf_pkg::C_U: mode_reg <= pmf_pkg::M_PEAK;
              pmf_pkg::C_D: begin
                mode_reg <= pmf_pkg::M_VSP;
                vsp_reg  <= 2'h0;
              end
              default: ;
            endcase
          end
        end
        pmf_pkg::M_PEAK: begin
          if (evt_w && (combo_reg == pmf_pkg::C_P || combo_reg == pmf_pkg::C_D)) begin
            mode_reg <= pmf_pkg::M_RUN;
          end
        end
        pmf_pkg::M_VSP: begin
          if (evt_w && combo_reg == pmf_pkg::C_D) begin
            if (vsp_reg == pmf_pkg::VSP_LAST) begin
              mode_reg <= pmf_pkg::M_RUN;
            end else begin
              vsp_reg <= vsp_reg + 2'h1;
            end
          end else if (evt_w && combo_reg == pmf_pkg::C_P) begin
            mode_reg <= pmf_pkg::M_RUN;
          end
        end
        pmf_pkg::M_EDIT: begin
          if (evt_w && combo_reg == pmf_pkg::C_P) begin
            if (step_after(step_reg, ctrl_reg) == pmf_pkg::S_END) begin
              mode_reg <= pmf_pkg::M_RUN;
            end else begin
              step_reg <= step_after(step_reg, ctrl_reg);
            end
          end
        end
        default: mode_reg <= pmf_pkg::M_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // parameters
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < pmf_pkg::N_PAR; i++) begin
        par_reg[i] <= '0;
      end
      par_reg[pmf_pkg::S_BR]  <= pmf_pkg::BR_MAX;
      par_reg[pmf_pkg::S_AHI] <= pmf_pkg::VAL_MAX;
    end else if (mode_reg == pmf_pkg::M_EDIT && evt_w) begin
      // dp and brightness edits take effect at once
      if (combo_reg == pmf_pkg::C_U && par_reg[step_reg] < lim_hi(step_reg)) begin
        par_reg[step_reg] <= par_reg[step_reg] + 16'sh0001;
      end else if (combo_reg == pmf_pkg::C_D && par_reg[step_reg] > lim_lo(step_reg)) begin
        par_reg[step_reg] <= par_reg[step_reg] - 16'sh0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // reading, peak and valley
  // ----------------------------------------------------------------
  assign rdin_val_w = rdin_reg[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_reg  <= '0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (conv_tick_reg) begin
      rd_reg  <= rdin_val_w;
      pos_reg <= rdin_reg[pmf_pkg::RD_POS_BIT] || rdin_val_w > pmf_pkg::VAL_MAX;
      neg_reg <= rdin_reg[pmf_pkg::RD_NEG_BIT] || rdin_val_w < pmf_pkg::VAL_MIN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peak_reg   <= '0;
      valley_reg <= '0;
    end else if (mode_reg == pmf_pkg::M_PEAK && evt_w && combo_reg == pmf_pkg::C_U) begin
      peak_reg   <= rd_reg;
      valley_reg <= rd_reg;
    end else if (conv_tick_reg) begin
      if (rdin_val_w > peak_reg) peak_reg <= rdin_val_w;
      if (rdin_val_w < valley_reg) valley_reg <= rdin_val_w;
    end
  end

  // ----------------------------------------------------------------
  // alarms
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_trip
    pmf_trip u_trip (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .sec_tick_i (sec_tick_reg),
      .reading_i  (rd_reg),
      .point_i    (par_reg[pmf_pkg::SP_STEP[g]]),
      .band_i     (par_reg[pmf_pkg::HY_STEP[g]]),
      .above_i    (par_reg[pmf_pkg::DIR_STEP[g]] == '0),
      .make_i     (g < 2 ? par_reg[pmf_pkg::MK_STEP[g]] : '0),
      .break_i    (g < 2 ? par_reg[pmf_pkg::BK_STEP[g]] : '0),
      .relay_o    (trip_w[g])
    );
  end

  // missing relays stay open, but the lamp still shows the alarm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lamp_o  <= 3'h0;
      relay_o <= 3'h0;
    end else begin
      lamp_o  <= trip_w;
      relay_o <= trip_w & ctrl_reg[pmf_pkg::CTRL_RLY_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // analog output
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [31:0] den;
    logic signed [31:0] num;
    den = 32'(par_reg[pmf_pkg::S_AHI]) - 32'(par_reg[pmf_pkg::S_ALO]);
    num = (32'(rd_reg) - 32'(par_reg[pmf_pkg::S_ALO])) * pmf_pkg::AOUT_FS;
    if (den == '0) begin
      aout_q = (rd_reg >= par_reg[pmf_pkg::S_AHI]) ? pmf_pkg::AOUT_FS : '0;
    end else begin
      aout_q = num / den;
    end
    if (aout_q < 0) aout_q = '0;
    if (aout_q > pmf_pkg::AOUT_FS) aout_q = pmf_pkg::AOUT_FS;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_reg[pmf_pkg::CTRL_AOUT_BIT]) begin
      aout_o <= '0;
    end else begin
      aout_o <= aout_q[15:0];
    end
  end

  // ----------------------------------------------------------------
  // display
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_o <= '0;
    end else begin
      disp_o       <= '0;
      disp_o.dp    <= par_reg[pmf_pkg::S_DP][2:0];
      disp_o.value <= rd_reg;
      case (mode_reg)
        pmf_pkg::M_LAMP: disp_o.lamp <= 1'b1;
        pmf_pkg::M_RUN: begin
          disp_o.seg_top <= pos_reg && blink_reg;
          disp_o.seg_bot <= neg_reg && !pos_reg && blink_reg;
          disp_o.blank   <= (pos_reg || neg_reg) && !blink_reg;
        end
        pmf_pkg::M_PEAK: disp_o.value <= blink_reg ? valley_reg : peak_reg;
        pmf_pkg::M_VSP: begin
          disp_o.name_sel <= blink_reg;
          disp_o.name     <= pmf_pkg::SP_STEP[vsp_reg];
          disp_o.value    <= par_reg[pmf_pkg::SP_STEP[vsp_reg]];
        end
        pmf_pkg::M_EDIT: begin
          disp_o.name_sel <= blink_reg;
          disp_o.name     <= step_reg;
          disp_o.value    <= par_reg[step_reg];
        end
        default: ;
      endcase
    end
  end

  // duty of level/4 on a four-phase cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_cnt_reg <= 2'h0;
      disp_pwm_o  <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 2'h1;
      disp_pwm_o  <= {1'b0, pwm_cnt_reg} < par_reg[pmf_pkg::S_BR][2:0];
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign wb_req_w = wb_cyc_i && wb_stb_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req_w && !wb_ack_o;
      case (wb_adr_i)
        pmf_pkg::A_CTRL: wb_dat_o <= {28'h0, ctrl_reg};
        pmf_pkg::A_READ: wb_dat_o <= rdin_reg;
        pmf_pkg::A_STAT: wb_dat_o <= {19'h0, step_reg, relay_o, mode_reg};
        pmf_pkg::A_PKVL: wb_dat_o <= {peak_reg, valley_reg};
        pmf_pkg::A_AOUT: wb_dat_o <= {16'h0, aout_o};
        default:         wb_dat_o <= '0;
      endcase
    end
  end

  // writes land on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= pmf_pkg::CTRL_RST;
      rdin_reg <= '0;
    end else if (wb_req_w && wb_we_i && wb_ack_o) begin
      if (wb_adr_i == pmf_pkg::A_CTRL && wb_sel_i[0]) ctrl_reg <= wb_dat_i[3:0];
      if (wb_adr_i == pmf_pkg::A_READ) begin
        for (int b = 0; b < 4; b++) rdin_reg[8*b +: 8] <= lane(rdin_reg, wb_dat_i, wb_sel_i, b);
      end
    end
  end

endmodule

// [pmf_pkg.sv]
package pmf_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int LAMP_MS    = 3000;
  localparam int CONV_MS    = 200;
  localparam int BLINK_MS   = 500;
  localparam int SEC_MS     = 1000;
  localparam int DEB_MS     = 20;
  localparam int LAMP_CYC   = LAMP_MS * CYC_PER_MS;
  localparam int CONV_CYC   = CONV_MS * CYC_PER_MS;
  localparam int BLINK_CYC  = BLINK_MS * CYC_PER_MS;
  localparam int SEC_CYC    = SEC_MS * CYC_PER_MS;
  localparam int DEB_CYC    = DEB_MS * CYC_PER_MS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_READ = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_PKVL = 8'h0C;
  localparam logic [7:0] A_AOUT = 8'h10;
  localparam int         CTRL_AOUT_BIT = 0;
  localparam int         CTRL_RLY_LSB  = 1;
  localparam logic [3:0] CTRL_RST      = 4'hF;
  localparam int         RD_POS_BIT    = 16;
  localparam int         RD_NEG_BIT    = 17;
  localparam int         STAT_RLY_LSB  = 5;
  localparam int         STAT_STEP_LSB = 8;

  // ----------------------------------------------------------------
  // values, steps and modes
  // ----------------------------------------------------------------
  localparam logic signed [15:0] VAL_MIN = 16'hF831;
  localparam logic signed [15:0] VAL_MAX = 16'h270F;
  localparam logic signed [15:0] DP_MAX  = 16'h0004;
  localparam logic signed [15:0] BR_MIN  = 16'h0001;
  localparam logic signed [15:0] BR_MAX  = 16'h0004;
  localparam logic signed [15:0] DIR_MAX = 16'h0001;
  localparam logic signed [31:0] AOUT_FS = 32'sh0000FFFF;
  localparam int N_PAR = 17;
  localparam logic [4:0] S_DP  = 5'h00, S_BR  = 5'h01, S_AHI = 5'h02, S_ALO = 5'h03;
  localparam logic [4:0] S_SP1 = 5'h04, S_HY1 = 5'h08, S_HY2 = 5'h0D;
  localparam logic [4:0] S_SP3 = 5'h0E, S_HY3 = 5'h10, S_END = 5'h1F;
  localparam logic [4:0] SP_STEP  [3] = '{5'h04, 5'h09, 5'h0E};
  localparam logic [4:0] DIR_STEP [3] = '{5'h05, 5'h0A, 5'h0F};
  localparam logic [4:0] MK_STEP  [3] = '{5'h06, 5'h0B, 5'h06};
  localparam logic [4:0] BK_STEP  [3] = '{5'h07, 5'h0C, 5'h07};
  localparam logic [4:0] HY_STEP  [3] = '{5'h08, 5'h0D, 5'h10};
  localparam logic [2:0] C_P = 3'h1, C_U = 3'h2, C_D = 3'h4, C_PU = 3'h3, C_PD = 3'h5;
  localparam logic [1:0] VSP_LAST = 2'h2;

  typedef enum logic [4:0] {
    M_LAMP = 5'h01, M_RUN = 5'h02, M_PEAK = 5'h04, M_VSP = 5'h08, M_EDIT = 5'h10
  } pmf_mode_t;

  typedef struct packed {
    logic              lamp;
    logic              blank;
    logic              seg_top;
    logic              seg_bot;
    logic              name_sel;
    logic [4:0]        name;
    logic [2:0]        dp;
    logic signed [15:0] value;
  } pmf_disp_t;

endpackage

// [pmf_debounce.sv]
`timescale 1ns/1ps
module pmf_debounce #(
  parameter int DEB_CYC = pmf_pkg::DEB_CYC
) (
  // system
  input  wire logic clk_i,
  input  wire logic rst_i,
  // raw pin and clean level
  input  wire logic btn_i,
  output logic      level_o
);
  logic        s1_reg;
  logic        s2_reg;
  logic [31:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= btn_i;
      s2_reg <= s1_reg;
    end
  end

  // level must stay changed for the full window before it is accepted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      level_o <= 1'b0;
    end else if (s2_reg == level_o) begin
      cnt_reg <= '0;
    end else if (cnt_reg == 32'(DEB_CYC - 1)) begin
      cnt_reg <= '0;
      level_o <= s2_reg;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule

// [pmf_trip.sv]
`timescale 1ns/1ps
module pmf_trip (
  // system
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               sec_tick_i,
  // settings and reading
  input  wire logic signed [15:0] reading_i,
  input  wire logic signed [15:0] point_i,
  input  wire logic signed [15:0] band_i,
  input  wire logic               above_i,
  input  wire logic        [15:0] make_i,
  input  wire logic        [15:0] break_i,
  // relay drive
  output logic                    relay_o
);
  logic signed [16:0] hi_w;
  logic signed [16:0] lo_w;
  logic               trip_reg;
  logic        [15:0] secs_reg;
  logic        [15:0] dly_w;

  // half the band above the point, half below
  assign hi_w  = 17'(point_i) + 17'(band_i >>> 1);
  assign lo_w  = 17'(point_i) - 17'(band_i >>> 1);
  assign dly_w = trip_reg ? make_i : break_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_reg <= 1'b0;
    end else if (17'(reading_i) > hi_w) begin
      trip_reg <= above_i;
    end else if (17'(reading_i) < lo_w) begin
      trip_reg <= !above_i;
    end
  end

  // first counted second may be partial: ticks are free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      secs_reg <= '0;
      relay_o  <= 1'b0;
    end else if (trip_reg == relay_o) begin
      secs_reg <= '0;
    end else if (dly_w == 16'h0000) begin
      relay_o <= trip_reg;
    end else if (sec_tick_i) begin
      if (secs_reg + 16'h0001 >= dly_w) begin
        relay_o  <= trip_reg;
        secs_reg <= '0;
      end else begin
        secs_reg <= secs_reg + 16'h0001;
      end
    end
  end
endmodule

// [pmf_panel_props.sv]
`timescale 1ns/1ps
module pmf_panel_props (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire pmf_pkg::pmf_disp_t disp_o,
  input wire logic [2:0]         lamp_o,
  input wire logic [2:0]         relay_o,
  input wire logic [15:0]        aout_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_relay_mask: assert property ((relay_o & ~lamp_o) == 3'h0)
    else $error("relay without lamp");
  a_flash_excl: assert property (!(disp_o.seg_top && disp_o.seg_bot))
    else $error("top and bottom together");
  a_lamp_start: assert property ($fell(rst_i) |-> ##[1:2] disp_o.lamp)
    else $error("no lamp test");
  a_aout_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == pmf_pkg::A_AOUT
    |-> wb_dat_o[15:0] == $past(aout_o)) else $error("aout readback");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h10
    |-> wb_dat_o == 32'h0) else $error("unmapped read");
endmodule
bind pmf_panel pmf_panel_props i_pmf_panel_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .disp_o, .lamp_o, .relay_o, .aout_o);

// [pmf_operator.sv]
`timescale 1ns/1ps
module pmf_operator (
  // system
  input  wire logic clk_i,
  // button pins, 1 = pressed
  output logic      btn_prog_o,
  output logic      btn_up_o,
  output logic      btn_dn_o
);
  initial begin
    {btn_dn_o, btn_up_o, btn_prog_o} = 3'h0;
  end
  // chord held together, then all released; both gaps outlast the debounce
  task automatic press(input logic [2:0] chord);
    @(posedge clk_i);
    {btn_dn_o, btn_up_o, btn_prog_o} <= chord;
    repeat (12) @(posedge clk_i);
    {btn_dn_o, btn_up_o, btn_prog_o} <= 3'h0;
    repeat (16) @(posedge clk_i);
  endtask
endmodule

// [test_panel_meter_front_panel_ui.sv]
`timescale 1ns/1ps
module test_panel_meter_front_panel_ui;
  logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]         wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i, wb_dat_o, rd;
  logic               btn_prog_i, btn_up_i, btn_dn_i, disp_pwm_o;
  pmf_pkg::pmf_disp_t disp_o;
  logic [2:0]         lamp_o, relay_o;
  logic [15:0]        aout_o;
  int                 miscompares = 0, checks = 0, cycles = 0;
  pmf_panel #(.LAMP_CYC(200), .CONV_CYC(20), .BLINK_CYC(16), .SEC_CYC(50), .DEB_CYC(4))
    i_pmf_panel (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .btn_prog_i, .btn_up_i, .btn_dn_i, .disp_o,
    .disp_pwm_o, .lamp_o, .relay_o, .aout_o);
  pmf_operator i_op (.clk_i, .btn_prog_o(btn_prog_i), .btn_up_o(btn_up_i),
    .btn_dn_o(btn_dn_i));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hF, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, pmf_pkg::A_STAT, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic s_alarm;
    wb(1'b1, pmf_pkg::A_READ, 32'h64);
    repeat (48) @(posedge clk_i);
    chk(32'(lamp_o), 32'h7);
    chk(32'(relay_o), 32'h7);
    wb(1'b1, pmf_pkg::A_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
    chk(32'(relay_o), 32'h0);
    wb(1'b0, pmf_pkg::A_AOUT, 32'h0);
    chk(rd, 32'h28F);
    wb(1'b1, pmf_pkg::A_READ, 32'hFFF6);
    repeat (48) @(posedge clk_i);
    chk(32'(lamp_o), 32'h0);
  endtask
  task automatic s_flash(input logic [31:0] d, input logic top);
    logic seen;
    seen = 1'b0;
    wb(1'b1, pmf_pkg::A_READ, d);
    repeat (80) begin
      @(posedge clk_i);
      seen |= top ? disp_o.seg_top : disp_o.seg_bot;
    end
    chk(32'(seen), 32'h1);
  endtask
  task automatic s_view;
    i_op.press(pmf_pkg::C_D);
    st(32'h1F, 32'h08);
    chk(32'(disp_o.name), 32'h4);
    i_op.press(pmf_pkg::C_P);
    i_op.press(pmf_pkg::C_U);
    st(32'h1F, 32'h04);
    wb(1'b0, pmf_pkg::A_PKVL, 32'h0);
    chk(rd, 32'h0064FFF6);
    i_op.press(pmf_pkg::C_U);
    wb(1'b0, pmf_pkg::A_PKVL, 32'h0);
    chk(rd, 32'h0);
    i_op.press(pmf_pkg::C_P);
  endtask
  task automatic s_edit;
    i_op.press(pmf_pkg::C_PU);
    st(32'h1F1F, 32'h0010);
    i_op.press(pmf_pkg::C_U);
    i_op.press(pmf_pkg::C_U);
    chk(32'(disp_o.dp), 32'h2);
    i_op.press(pmf_pkg::C_D);
    chk(32'(disp_o.dp), 32'h1);
    i_op.press(pmf_pkg::C_P);
    st(32'h1F1F, 32'h0110);
    repeat (3) i_op.press(pmf_pkg::C_P);
    st(32'h1F, 32'h02);
    i_op.press(pmf_pkg::C_PD);
    st(32'h1F1F, 32'h0410);
    repeat (5) i_op.press(pmf_pkg::C_P);
    st(32'h1F, 32'h02);
  endtask
  initial begin
    {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b01000;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hF, 32'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, pmf_pkg::A_CTRL, 32'h0);
    chk(rd, 32'hF);
    st(32'h1F, 32'h01);
    wb(1'b1, 8'h20, 32'h5);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    repeat (200) @(posedge clk_i);
    st(32'h1F, 32'h02);
    chk(32'(disp_pwm_o), 32'h1);
    s_alarm;
    s_flash(32'h10000, 1'b1);
    s_flash(32'h20000, 1'b0);
    s_view;
    s_edit;
    report_and_stop;
  end
endmodule
